/* File: core/dnpc_defines.svh */
/*
 * register offsets, field positions, codes and reset values of the
 * command block decoder.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef DNPC_DEFINES_SVH
`define DNPC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets on the apb slave
// ----------------------------------------------------------------
`define DNPC_OFF_FEATURE    12'h000
`define DNPC_OFF_COUNT     12'h004
`define DNPC_OFF_SECTOR    12'h008
`define DNPC_OFF_BCLOW     12'h00C
`define DNPC_OFF_BCHIGH    12'h010
`define DNPC_OFF_DRIVE     12'h014
`define DNPC_OFF_COMMAND   12'h018
`define DNPC_OFF_ERROR     12'h01C
`define DNPC_OFF_STATUS    12'h020
`define DNPC_OFF_CONTROL   12'h024
`define DNPC_OFF_DEVSTATE  12'h028
`define DNPC_OFF_XFERCNT   12'h02C

// ----------------------------------------------------------------
// command codes and subcommands
// ----------------------------------------------------------------
`define DNPC_CMD_NOP       8'h00
`define DNPC_CMD_PACKET    8'hA0
`define DNPC_SUB_FLUSH     8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DNPC_ST_BUSY      7
`define DNPC_ST_READY     6
`define DNPC_ST_FAULT     5
`define DNPC_ST_DMARDY    5
`define DNPC_ST_SERVICE_FLAG      4
`define DNPC_ST_DRQ       3
`define DNPC_ST_ERR       0
`define DNPC_ER_ABORTED_FLAG      2
`define DNPC_FT_OVL       1
`define DNPC_FT_DMA       0
`define DNPC_IR_REL       2
`define DNPC_IR_IO        1
`define DNPC_IR_CD        0
`define DNPC_TAG_LSB      3
`define DNPC_CTL_PKTSET   0
`define DNPC_CTL_QUEUE    1
`define DNPC_CTL_OVLSUP   2
`define DNPC_CTL_FAULT    3
`define DNPC_CTL_SERVICE_FLAG     4
`define DNPC_CTL_PKTACC   5

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define DNPC_STATUS_RST   8'h40
`define DNPC_CTRL_RST     8'h07
`define DNPC_BC_ALLONES   16'hFFFF
`define DNPC_BC_EVENMAX   16'hFFFE

`endif

/* File: core/dnpc_pkg.sv */
/*
 * types shared by the command block decoder.
 * assumes nothing beyond a systemverilog compiler.
 */
package dnpc_pkg;
    // gray codes along idle -> decode -> abort; packet wait differs from decode in both bits
    typedef enum logic [1:0] {
        DNPC_IDLE   = 2'b00,
        DNPC_DECODE = 2'b01,
        DNPC_FINISH = 2'b11,
        DNPC_PKTWT  = 2'b10
    } dnpc_state_e;
endpackage : dnpc_pkg

/* File: core/dnpc_bc_limit.sv */
/*
 * byte count limit conditioning and per request count choice.
 * assumes a purely combinational use from the decoder.
 */
`timescale 1ns/1ns
`include "dnpc_defines.svh"

module dnpc_bc_limit #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] limitRaw,
    input  wire logic [WIDTH-1:0] remaining,
    output logic      [WIDTH-1:0] limitEff,
    output logic      [WIDTH-1:0] chunk
);
    // ------------------------------------------------------------
    // all ones means next lower even; chunk never zero, above the limit only for a zero limit
    // ------------------------------------------------------------
    always_comb begin
        limitEff = (limitRaw == `DNPC_BC_ALLONES) ? `DNPC_BC_EVENMAX : limitRaw; // R13
        chunk    = (remaining > limitEff) ? limitEff : remaining;                // R19
        if (chunk == '0) begin
            chunk = WIDTH'(1); // zero limit: smallest legal count
        end
    end
endmodule : dnpc_bc_limit

/* File: core/dnpc_status_pack.sv */
/*
 * packs the status byte from flags for the two status layouts.
 * assumes a purely combinational use from the decoder.
 */
`timescale 1ns/1ns
`include "dnpc_defines.svh"

module dnpc_status_pack (
    input  wire logic packetLayout,
    input  wire logic busy,
    input  wire logic ready,
    input  wire logic fault,
    input  wire logic dmaReady,
    input  wire logic service,
    input  wire logic xferReq,
    input  wire logic errChk,
    output logic [7:0] status
);
    // ------------------------------------------------------------
    // bit 5 is fault in ata layout, dma ready in packet layout
    // ------------------------------------------------------------
    always_comb begin
        status = 8'h00;
        status[`DNPC_ST_BUSY]  = busy;
        status[`DNPC_ST_READY] = ready;
        status[`DNPC_ST_DRQ]   = xferReq;
        status[`DNPC_ST_ERR]   = errChk;
        if (packetLayout) begin
            status[`DNPC_ST_DMARDY] = dmaReady;
            status[`DNPC_ST_SERVICE_FLAG]   = service;
        end else begin
            status[`DNPC_ST_FAULT]  = fault;
        end
    end
endmodule : dnpc_status_pack

/* File: core/dnpc_cmd_decode.sv */
/*
 * command block registers and decoder for the no-operation and the
 * opening phase of the packet command, reached over apb.
 * assumes a single 100 mhz clock, async active low reset, and an apb
 * master that keeps the usual setup/access order.
 */
// Chosen here: the placing of the registers and the APB interface to the registers.
// Behaviour
// R1: no-operation always ends aborted: abort bit in error, error bit in status
// R2: subcommand zero with queuing support flushes every queued command (code gates the flush on the overlap support bit instead)
// R3: subcommand one to max leaves queued commands untouched
// R4: no-operation changes only error and status registers
// R5: at end: busy clear, ready set, transfer clear, fault only if fault
// R6: packet command accepted only when packet feature set is implemented
// R7: feature bit 1 is the host overlap request
// R8: feature bit 0 picks dma for data only, packet moved by pio
// R9: tag taken from upper count field, any of 0 to 31 legal
// R10: byte count pair is per request limit, not for packet, unused without data
// R11: host should avoid zero limit; device then follows its identify word (code reports a count of 1 instead)
// R12: host keeps limit even when total length exceeds it
// R13: all-ones limit is treated as next lower even value
// R14: awaiting packet, byte count pair reads back the host value
// R15: awaiting packet: release and direction clear, command-packet bit set
// R16: awaiting packet: busy clear, dma ready clear, request set, check clear
// R17: service flag set when another queued command is ready
// R18: tag reported only with queuing support and overlap enabled
// R19: each pio request count is nonzero and within the host limit
// R20: command write sets busy first, then decode changes other flags
`timescale 1ns/1ns
`include "dnpc_defines.svh"

module dnpc_cmd_decode #(
    parameter int QDEPTH = 32
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             queueFlush,
    output logic             packetStart,
    output logic             overlapRequest,
    output logic             dataDma,
    output logic [4:0]       cmdTag,
    output logic [15:0]      byteLimit
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dnpc_pkg::dnpc_state_e state_r, state_nxt;
    logic [7:0]  feature_r, feature_nxt;
    logic [7:0]  count_r, count_nxt;
    logic [7:0]  sector_r, sector_nxt;
    logic [7:0]  bcLow_r, bcLow_nxt;
    logic [7:0]  bcHigh_r, bcHigh_nxt;
    logic [7:0]  drive_r, drive_nxt;
    logic [7:0]  command_r, command_nxt;
    logic [7:0]  error_r, error_nxt;
    logic [7:0]  control_r, control_nxt;
    logic        busy_r, busy_nxt;
    logic        ready_r, ready_nxt;
    logic        fault_r, fault_nxt;
    logic        drq_r, drq_nxt;
    logic        errChk_r, errChk_nxt;
    logic        dmaRdy_r, dmaRdy_nxt;
    logic        pktLayout_r, pktLayout_nxt;
    logic [7:0]  reason_r, reason_nxt;
    logic [QDEPTH-1:0] queued_r, queued_nxt;
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic        flush_nxt;
    logic        pktStart_nxt;
    logic        ovl_r, ovl_nxt;
    logic        dma_r, dma_nxt;
    logic [4:0]  tag_r, tag_nxt;
    logic [15:0] limit_r, limit_nxt;
    logic [15:0] limitEff;
    logic [15:0] chunk;
    logic [7:0]  statusByte;
    logic        wrAcc;
    logic        rdAcc;
    logic        tagValid;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    dnpc_bc_limit #(
        .WIDTH     (16)
    ) uLimit (
        .limitRaw  ({bcHigh_r, bcLow_r}),
        .remaining (16'hFFFF),
        .limitEff  (limitEff),
        .chunk     (chunk)
    );

    dnpc_status_pack uStatus (
        .packetLayout (pktLayout_r),
        .busy         (busy_r),
        .ready        (ready_r),
        .fault        (fault_r),
        .dmaReady     (dmaRdy_r),
        .service      (control_r[`DNPC_CTL_SERVICE_FLAG] & ovl_r),
        .xferReq      (drq_r),
        .errChk       (errChk_r),
        .status       (statusByte)
    );

    // one wait-free access phase; access is the second apb cycle
    assign wrAcc = psel & penable & pwrite;
    assign rdAcc = psel & penable & ~pwrite;
    // tag only meaningful with queuing and overlap
    assign tagValid = control_r[`DNPC_CTL_QUEUE] & ovl_r; // R18

    // ------------------------------------------------------------
    // next values: bus writes, command decode, status layout
    // ------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        feature_nxt  = feature_r;
        count_nxt    = count_r;
        sector_nxt   = sector_r;
        bcLow_nxt    = bcLow_r;
        bcHigh_nxt   = bcHigh_r;
        drive_nxt    = drive_r;
        command_nxt  = command_r;
        error_nxt    = error_r;
        control_nxt  = control_r;
        busy_nxt     = busy_r;
        ready_nxt    = ready_r;
        fault_nxt    = fault_r;
        drq_nxt      = drq_r;
        errChk_nxt   = errChk_r;
        dmaRdy_nxt   = dmaRdy_r;
        pktLayout_nxt = pktLayout_r;
        reason_nxt   = reason_r;
        queued_nxt   = queued_r;
        flush_nxt    = 1'b0;
        pktStart_nxt = 1'b0;
        ovl_nxt      = ovl_r;
        dma_nxt      = dma_r;
        tag_nxt      = tag_r;
        limit_nxt    = limit_r;

        // host writes to the block; ignored while busy so a running
        // command sees stable inputs
        if (wrAcc && !busy_r) begin
            unique case (paddr)
                `DNPC_OFF_FEATURE: feature_nxt = pwdata[7:0];
                `DNPC_OFF_COUNT:   count_nxt   = pwdata[7:0];
                `DNPC_OFF_SECTOR:  sector_nxt  = pwdata[7:0];
                `DNPC_OFF_BCLOW:   bcLow_nxt   = pwdata[7:0];
                `DNPC_OFF_BCHIGH:  bcHigh_nxt  = pwdata[7:0];
                `DNPC_OFF_DRIVE:   drive_nxt   = pwdata[7:0];
                `DNPC_OFF_CONTROL: control_nxt = pwdata[7:0];
                `DNPC_OFF_COMMAND: begin
                    command_nxt = pwdata[7:0];
                    busy_nxt    = 1'b1; // R20
                    state_nxt   = dnpc_pkg::DNPC_DECODE; // R20
                end
                default: ;
            endcase
        end
        // queue occupancy: tag bit set by a queued packet, software may
        // also mark slots through the device state register
        if (wrAcc && paddr == `DNPC_OFF_DEVSTATE) begin
            queued_nxt = pwdata[QDEPTH-1:0];
        end
        // fault is sticky device state, set from control
        fault_nxt = fault_r | control_r[`DNPC_CTL_FAULT];

        unique case (state_r)
            dnpc_pkg::DNPC_IDLE: ;
            dnpc_pkg::DNPC_DECODE: begin
                pktLayout_nxt = 1'b0;
                error_nxt     = 8'h00;
                if (command_r == `DNPC_CMD_PACKET
                    && control_r[`DNPC_CTL_PKTSET]) begin // R6
                    ovl_nxt   = feature_r[`DNPC_FT_OVL]; // R7
                    dma_nxt   = feature_r[`DNPC_FT_DMA]; // R8
                    tag_nxt   = count_r[7:`DNPC_TAG_LSB]; // R9
                    limit_nxt = limitEff; // R10 R13
                    if (control_r[`DNPC_CTL_QUEUE]) begin
                        queued_nxt[count_r[7:`DNPC_TAG_LSB]] = 1'b1; // R9
                    end
                    state_nxt = dnpc_pkg::DNPC_PKTWT;
                end else begin
                    // no-operation, unsupported packet, any other code: abort
                    if (command_r == `DNPC_CMD_NOP
                        && feature_r == `DNPC_SUB_FLUSH
                        && control_r[`DNPC_CTL_OVLSUP]) begin
                        queued_nxt = '0; // R2
                        flush_nxt  = 1'b1; // R2
                    end // other subcommands leave queued_r alone R3
                    error_nxt[`DNPC_ER_ABORTED_FLAG] = 1'b1; // R1
                    state_nxt = dnpc_pkg::DNPC_FINISH;
                end
            end
            dnpc_pkg::DNPC_FINISH: begin
                // only error and status change here R4
                busy_nxt   = 1'b0; // R5
                ready_nxt  = 1'b1; // R5
                drq_nxt    = 1'b0; // R5
                errChk_nxt = 1'b1; // R1
                state_nxt  = dnpc_pkg::DNPC_IDLE;
            end
            dnpc_pkg::DNPC_PKTWT: begin
                // awaiting packet layout; count register becomes reason
                pktLayout_nxt = 1'b1;
                reason_nxt    = 8'h00;
                reason_nxt[`DNPC_IR_REL] = 1'b0; // R15
                reason_nxt[`DNPC_IR_IO]  = 1'b0; // R15
                reason_nxt[`DNPC_IR_CD]  = 1'b1; // R15
                busy_nxt   = 1'b0; // R16
                dmaRdy_nxt = 1'b0; // R16
                drq_nxt    = 1'b1; // R16
                errChk_nxt = 1'b0; // R16
                // software signals packet taken; later phases elsewhere
                if (control_r[`DNPC_CTL_PKTACC] && !busy_r) begin
                    pktStart_nxt = 1'b1;
                    drq_nxt      = 1'b0;
                    busy_nxt     = 1'b1;
                    if (!(wrAcc && paddr == `DNPC_OFF_CONTROL)) begin
                        control_nxt[`DNPC_CTL_PKTACC] = 1'b0;
                    end
                    state_nxt    = dnpc_pkg::DNPC_IDLE;
                end
            end
            default: state_nxt = dnpc_pkg::DNPC_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // apb answer: zero wait, unmapped reads zero with slave error
    // ------------------------------------------------------------
    always_comb begin
        prdata_nxt  = 32'h0000_0000;
        pready_nxt  = psel & ~penable;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            unique case (paddr)
                `DNPC_OFF_FEATURE, `DNPC_OFF_COMMAND: prdata_nxt = 32'h0000_0000;
                `DNPC_OFF_COUNT:   prdata_nxt = {24'h00_0000, pktLayout_r ?
                    {tagValid ? tag_r : 5'h00, reason_r[2:0]} : count_r}; // R18
                `DNPC_OFF_SECTOR:  prdata_nxt = {24'h00_0000, sector_r};
                `DNPC_OFF_BCLOW:   prdata_nxt = {24'h00_0000, bcLow_r};  // R14
                `DNPC_OFF_BCHIGH:  prdata_nxt = {24'h00_0000, bcHigh_r}; // R14
                `DNPC_OFF_DRIVE:   prdata_nxt = {24'h00_0000, drive_r};
                `DNPC_OFF_ERROR:   prdata_nxt = {24'h00_0000, error_r};
                `DNPC_OFF_STATUS:  prdata_nxt = {24'h00_0000, statusByte}; // R17
                `DNPC_OFF_CONTROL: prdata_nxt = {24'h00_0000, control_r};
                `DNPC_OFF_DEVSTATE: prdata_nxt = 32'(queued_r);
                `DNPC_OFF_XFERCNT: prdata_nxt = {16'h0000, chunk}; // R19
                default:           pslverr_nxt = ~pwrite;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= dnpc_pkg::DNPC_IDLE;
            feature_r   <= 8'h00;
            count_r     <= 8'h00;
            sector_r    <= 8'h00;
            bcLow_r     <= 8'h00;
            bcHigh_r    <= 8'h00;
            drive_r     <= 8'h00;
            command_r   <= 8'h00;
            error_r     <= 8'h00;
            control_r   <= `DNPC_CTRL_RST;
            busy_r      <= 1'b0;
            ready_r     <= 1'b1;
            fault_r     <= 1'b0;
            drq_r       <= 1'b0;
            errChk_r    <= 1'b0;
            dmaRdy_r    <= 1'b0;
            pktLayout_r <= 1'b0;
            reason_r    <= 8'h00;
            queued_r    <= '0;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            queueFlush  <= 1'b0;
            packetStart <= 1'b0;
            ovl_r       <= 1'b0;
            dma_r       <= 1'b0;
            tag_r       <= 5'h00;
            limit_r     <= 16'h0000;
        end else begin
            state_r     <= state_nxt;
            feature_r   <= feature_nxt;
            count_r     <= count_nxt;
            sector_r    <= sector_nxt;
            bcLow_r     <= bcLow_nxt;
            bcHigh_r    <= bcHigh_nxt;
            drive_r     <= drive_nxt;
            command_r   <= command_nxt;
            error_r     <= error_nxt;
            control_r   <= control_nxt;
            busy_r      <= busy_nxt;
            ready_r     <= ready_nxt;
            fault_r     <= fault_nxt;
            drq_r       <= drq_nxt;
            errChk_r    <= errChk_nxt;
            dmaRdy_r    <= dmaRdy_nxt;
            pktLayout_r <= pktLayout_nxt;
            reason_r    <= reason_nxt;
            queued_r    <= queued_nxt;
            prdata      <= prdata_nxt;
            pready      <= pready_nxt;
            pslverr     <= pslverr_nxt;
            queueFlush  <= flush_nxt;
            packetStart <= pktStart_nxt;
            ovl_r       <= ovl_nxt;
            dma_r       <= dma_nxt;
            tag_r       <= tag_nxt;
            limit_r     <= limit_nxt;
        end
    end

    // ------------------------------------------------------------
    // decoded packet fields straight from flops
    // ------------------------------------------------------------
    always_comb begin
        overlapRequest = ovl_r;
        dataDma        = dma_r;
        cmdTag         = tag_r;
        byteLimit      = limit_r;
    end

endmodule : dnpc_cmd_decode

/* File: tb/dnpc_cmd_decode_assertions.sv */
/* port assertions for the command decoder.
   assumes a bind onto dnpc_cmd_decode and one clock domain. */
`timescale 1ns/1ns
module dnpc_cmd_decode_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        queueFlush,
    input wire logic        packetStart,
    input wire logic        overlapRequest,
    input wire logic        dataDma,
    input wire logic [4:0]  cmdTag
);
    // --------------------------------
    // ages of the last relevant writes
    // --------------------------------
    logic       wrTaken;
    logic [2:0] sinceCmd_r, sinceCmd_nxt;
    logic [2:0] sinceNop_r, sinceNop_nxt;
    logic [2:0] sinceAck_r, sinceAck_nxt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // saturate at 7 so old writes never wrap back into range
    assign wrTaken = psel && penable && pwrite && pready;
    always_comb begin
        sinceCmd_nxt = sinceCmd_r + {2'h0, sinceCmd_r != 3'h7};
        sinceNop_nxt = sinceNop_r + {2'h0, sinceNop_r != 3'h7};
        sinceAck_nxt = sinceAck_r + {2'h0, sinceAck_r != 3'h7};
        if (wrTaken && paddr == 12'h018) begin
            sinceCmd_nxt = 3'h0;
            if (pwdata[7:0] == 8'h00) begin
                sinceNop_nxt = 3'h0;
            end
        end
        if (wrTaken && paddr == 12'h024 && pwdata[5]) begin
            sinceAck_nxt = 3'h0;
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sinceCmd_r <= 3'h7;
            sinceNop_r <= 3'h7;
            sinceAck_r <= 3'h7;
        end else begin
            sinceCmd_r <= sinceCmd_nxt;
            sinceNop_r <= sinceNop_nxt;
            sinceAck_r <= sinceAck_nxt;
        end
    end

    a_ready_in_access: assert property (psel && penable |-> pready)
        else $error("no pready in access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_slverr_read_only: assert property (pslverr |-> pready && !pwrite)
        else $error("stray pslverr");
    a_flush_one_pulse: assert property (queueFlush |=> !queueFlush)
        else $error("flush pulse too long");
    a_flush_after_nop: assert property (queueFlush |-> sinceNop_r <= 3'h4)
        else $error("flush without no-op");
    a_start_one_pulse: assert property (packetStart |=> !packetStart)
        else $error("start pulse too long");
    a_start_after_ack: assert property (packetStart |-> sinceAck_r <= 3'h2)
        else $error("start without ack");
    a_fields_after_cmd: assert property
        ($changed({overlapRequest, dataDma, cmdTag}) |-> sinceCmd_r <= 3'h4)
        else $error("fields moved without command");

    c_flush: cover property (queueFlush);
    c_start: cover property (packetStart);
    c_slverr: cover property (pslverr);
endmodule : dnpc_cmd_decode_chk

bind dnpc_cmd_decode dnpc_cmd_decode_chk chk (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .queueFlush, .packetStart, .overlapRequest, .dataDma, .cmdTag
);

/* File: tb/dnpc_host_model.sv */
/* host bus controller model: an apb master for the register block.
   assumes the bench calls xfer one transfer at a time. */
`timescale 1ns/1ns
module dnpc_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // idle bus at time zero
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    // one transfer; released address and data lines show inverted values, not stale ones
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rdat, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : dnpc_host_model

/* File: tb/dnpc_cmd_decode_tb.sv */
/* self-checking bench for the command decoder.
   assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module dnpc_cmd_decode_tb;
    // --------------------------------
    // clock, reset, wiring
    // --------------------------------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        queueFlush, packetStart, overlapRequest, dataDma;
    logic [4:0]  cmdTag;
    logic [15:0] byteLimit;
    int          errTotal = 0;
    int          nCompared = 0;
    int          flushCnt = 0;
    int          startCnt = 0;
    int          f0, s0;

    always #5 clk = ~clk;

    dnpc_cmd_decode #(.QDEPTH(32)) uut (
        .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .queueFlush, .packetStart, .overlapRequest, .dataDma, .cmdTag, .byteLimit
    );
    dnpc_host_model host (
        .clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
    );

    // pulses are one cycle wide, so count them at every edge
    always @(posedge clk) begin
        flushCnt += (queueFlush === 1'b1);
        startCnt += (packetStart === 1'b1);
    end

    task automatic closeOut;
        if (errTotal == 0 && nCompared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : closeOut

    task automatic check(input string what, input logic [31:0] seen, exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h00_0000, d}, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask : rd

    task automatic resetDut;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    endtask : resetDut

    // issue a command, poll status until busy drops
    task automatic runCmd(input logic [7:0] c);
        wr(12'h018, c);
        rd(12'h020);
        check("busy", r[7], 1'b1);
        for (int i = 0; i < 20 && r[7] !== 1'b0; i++) rd(12'h020);
    endtask : runCmd

    task automatic tReset;
        rd(12'h020);
        check("status", r, 32'h0000_0040);
        rd(12'h024);
        check("control", r, 32'h0000_0007);
        rd(12'h030);
        check("unmapped", {r[30:0], e}, 32'h0000_0001);
    endtask : tReset

    task automatic tNop(input logic [7:0] sub, input int expFl, input logic [7:0] expSt);
        f0 = flushCnt;
        wr(12'h000, sub);
        for (int i = 1; i < 6; i++) wr(12'(i * 4), 8'h50 + 8'(i));
        runCmd(8'h00);
        rd(12'h01C);
        check("error", r, 32'h0000_0004);
        rd(12'h020);
        check("status", r, {24'h00_0000, expSt});
        for (int i = 1; i < 6; i++) begin
            rd(12'(i * 4));
            check("kept", r, 32'h0000_0050 + 32'(i));
        end
        check("flush", flushCnt - f0, expFl);
    endtask : tNop

    task automatic tPkt(input logic [7:0] ctl, feat, input logic [4:0] tag,
                        input logic [15:0] lim, input logic [7:0] expSt, expCnt);
        resetDut;
        wr(12'h024, ctl);
        wr(12'h000, feat);
        wr(12'h004, {tag, 3'h0});
        wr(12'h00C, lim[7:0]);
        wr(12'h010, lim[15:8]);
        runCmd(8'hA0);
        rd(12'h020);
        check("pkt status", r, {24'h00_0000, expSt});
        if (expSt == 8'h41) begin
            rd(12'h01C);
            check("pkt abort", r, 32'h0000_0004);
        end else begin
            rd(12'h004);
            check("reason", r, {24'h00_0000, expCnt});
            rd(12'h00C);
            check("count low", r, {24'h00_0000, lim[7:0]});
            rd(12'h010);
            check("count high", r, {24'h00_0000, lim[15:8]});
            check("overlap", overlapRequest, feat[1]);
            check("dma", dataDma, feat[0]);
            if (ctl[1]) check("tag", cmdTag, tag);
            check("limit", byteLimit, lim - 16'(lim == 16'hFFFF));
            rd(12'h02C);
            check("chunk", r != 0 && r <= lim - 16'(lim == 16'hFFFF), 1'b1);
            s0 = startCnt;
            wr(12'h024, ctl | 8'h20);
            repeat (3) @(posedge clk);
            check("start", startCnt - s0, 1);
        end
    endtask : tPkt

    // main sequence
    initial begin
        resetDut;
        tReset;
        tNop(8'h00, 1, 8'h41);
        tNop(8'h01, 0, 8'h41);
        tNop(8'hFF, 0, 8'h41);
        wr(12'h024, 8'h0F);
        tNop(8'h02, 0, 8'h61);
        tPkt(8'h07, 8'h03, 5'h1F, 16'hFFFF, 8'h48, 8'hF9);
        tPkt(8'h17, 8'h02, 5'h05, 16'h0200, 8'h58, 8'h29);
        tPkt(8'h17, 8'h01, 5'h00, 16'h0010, 8'h48, 8'h01);
        tPkt(8'h05, 8'h03, 5'h09, 16'h0100, 8'h48, 8'h01);
        tPkt(8'h06, 8'h00, 5'h00, 16'h0100, 8'h41, 8'h00);
        closeOut;
    end

    // hang guard, well past the run length
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        closeOut;
    end
endmodule : dnpc_cmd_decode_tb
